// ### hw/cpdr_regs.sv
// cache parity diagnostic register bank: control, capture, transfer, return pc
//
// Operation
// - wst steers tag ops to way-select array when scratchpad route is clear
// - scratchpad route sends index ops to scratchpad
// - control bits 27:8 read zero
// - icache/dcache parity fields hold data parity
// - parity exception loads whole capture register
// - bit 31 marks instruction or data
// - level bit read-only, resets zero
// - data and tag fault bits
// - snoop origin bit; external bit reads zero
// - both-sides bit, fields describe instruction fault
// - fatal bit on dirty victim, write-back miss way or combined faults
// - scratchpad fault bit read-only, reset zero
// - way dirty fault bit from way-select ram
// - way field reports faulting way
// - index field gives byte-aligned double-word index
// - tag bits 31:10 carry physical line address
// - valid, dirty-needs-valid, lock bits
// - tag parity loaded, stored under override
// - test mode dirty parity, dirty, history fields
// - tag load fills data; data store in test
// - return pc captures restart address
// - return pc read/write mixes instruction set bit
// - parity enable, zero when not built
// - override selects stored over generated parity
`timescale 1ns/1ps
module cpdr_regs
    import cpdr_pkg::*;
#(
    parameter bit PARITY_BUILT = 1'b1
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // coprocessor move port
    input  wire logic        cop_rd_i,
    input  wire logic        cop_wr_i,
    input  wire logic [2:0]  cop_sel_i,
    input  wire logic [31:0] cop_wdata_i,
    output logic      [31:0] cop_rdata_o,
    // indexed cache operation request from the pipeline
    input  wire logic        cop_op_i,
    input  wire logic [1:0]  cop_op_code_i,
    input  wire logic        cop_op_icache_i,
    // read-back from the arrays for a tag load
    input  wire logic        arr_ld_valid_i,
    input  wire logic [31:0] arr_ld_tag_i,
    input  wire logic        arr_ld_tag_par_i,
    input  wire logic [31:0] arr_ld_data_i,
    input  wire logic [3:0]  arr_ld_data_par_i,
    input  wire logic [3:0]  arr_ld_ws_dpar_i,
    input  wire logic [3:0]  arr_ld_ws_dirty_i,
    input  wire logic [5:0]  arr_ld_ws_lru_i,
    // array write/read strobes
    output logic             tag_wr_o,
    output logic             tag_rd_o,
    output logic             ws_wr_o,
    output logic             ws_rd_o,
    output logic             data_wr_o,
    output logic             spad_wr_o,
    output logic             spad_rd_o,
    output logic      [31:0] arr_wdata_o,
    output logic      [3:0]  arr_wpar_o,
    output logic             parity_on_o,
    // parity error event from the cache controller
    input  wire logic        perr_i,
    input  wire logic        perr_data_ref_i,
    input  wire logic        perr_data_ram_i,
    input  wire logic        perr_tag_ram_i,
    input  wire logic        perr_snoop_i,
    input  wire logic        perr_both_i,
    input  wire logic        perr_dirty_victim_i,
    input  wire logic        perr_wb_miss_way_i,
    input  wire logic        perr_spad_i,
    input  wire logic        perr_way_dirty_i,
    input  wire logic [1:0]  perr_way_i,
    input  wire logic [19:0] perr_index_i,
    // restart address capture on error exception; reset clears it to zero
    input  wire logic        err_exc_i,
    input  wire logic [31:0] err_restart_pc_i,
    input  wire logic        err_isa_i,
    output logic      [1:0]  instr_set_select_o,
    output logic      [31:0] fault_return_pc_o
);
    logic [31:0] ctl_q, ctl_d;
    logic [31:0] flt_q, flt_d;
    logic [31:0] tag_q, tag_d;
    logic [31:0] dat_q, dat_d;
    logic [31:0] pc_q, pc_d;
    logic [1:0]  isa_q, isa_d;
    logic [31:0] rdata_q, rdata_d;
    logic        tag_wr_q, tag_wr_d;
    logic        tag_rd_q, tag_rd_d;
    logic        ws_wr_q, ws_wr_d;
    logic        ws_rd_q, ws_rd_d;
    logic        data_wr_q, data_wr_d;
    logic        spad_wr_q, spad_wr_d;
    logic        spad_rd_q, spad_rd_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wpar_q, wpar_d;
    logic [3:0]  gen_bpar;
    logic        gen_wpar;
    logic        par_on, override, way_select_test, scratchpad_route;
    logic [31:0] tag_mask;

    assign par_on   = ctl_q[CPDR_CTL_PARITY_ON];
    assign override = ctl_q[CPDR_CTL_OVERRIDE];
    assign way_select_test      = ctl_q[CPDR_CTL_WST];
    assign scratchpad_route      = ctl_q[CPDR_CTL_SPR];
    assign tag_mask = way_select_test ? CPDR_TAG_MASK_WST : CPDR_TAG_MASK_NORM;

    // generated parity for the word being sent to the arrays
    cpdr_parity #(
        .BYTES (4)
    ) u_par (
        .word_i     (wdata_d),
        .byte_par_o (gen_bpar),
        .word_par_o (gen_wpar)
    );

    // control register: software writes, tag loads refresh parity fields
    always_comb begin
        ctl_d = ctl_q;
        if (cop_wr_i && cop_sel_i == CPDR_SEL_CTRL) begin
            // parity enable only writable when built
            ctl_d[CPDR_CTL_PARITY_ON] = PARITY_BUILT & cop_wdata_i[CPDR_CTL_PARITY_ON];
            ctl_d[CPDR_CTL_OVERRIDE]  = cop_wdata_i[CPDR_CTL_OVERRIDE];
            ctl_d[CPDR_CTL_WST]       = cop_wdata_i[CPDR_CTL_WST];
            ctl_d[CPDR_CTL_SPR]       = cop_wdata_i[CPDR_CTL_SPR];
            ctl_d[7:0]                = cop_wdata_i[7:0];
        end
        if (arr_ld_valid_i) begin
            // load parity from the selected data word, zero when disabled
            if (cop_op_icache_i) begin
                ctl_d[CPDR_CTL_IPAR_LSB +: 4] = par_on ? arr_ld_data_par_i : 4'h0;
            end else begin
                ctl_d[CPDR_CTL_DPAR_LSB +: 4] = par_on ? arr_ld_data_par_i : 4'h0;
            end
        end
        ctl_d[27:8] = 20'h0_0000;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctl_q <= CPDR_CTL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // fault capture: loaded whole on each parity error exception
    always_comb begin
        flt_d = flt_q;
        if (perr_i) begin
            // every field rewritten for the new fault
            flt_d = 32'h0000_0000;
            // instruction 0, data 1; keeps instruction view on both
            flt_d[CPDR_FLT_REF]      = perr_data_ref_i & ~perr_both_i;
            // only primary-level faults are seen here
            flt_d[CPDR_FLT_LEVEL]    = 1'b0;
            // data and tag ram fault flags
            flt_d[CPDR_FLT_DATA]     = perr_data_ram_i;
            flt_d[CPDR_FLT_TAG]      = perr_tag_ram_i;
            // origin of request; external fault unsupported
            flt_d[CPDR_FLT_SNOOP]    = perr_snoop_i;
            flt_d[CPDR_FLT_EXTERN]   = 1'b0;
            flt_d[CPDR_FLT_BOTH]     = perr_both_i;
            flt_d[CPDR_FLT_FATAL]    = perr_dirty_victim_i | perr_wb_miss_way_i | perr_both_i;
            flt_d[CPDR_FLT_SPAD]     = perr_spad_i;
            flt_d[CPDR_FLT_WAYDIRTY] = perr_way_dirty_i;
            // way is meaningless for tag or scratchpad faults
            flt_d[CPDR_FLT_WAY_LSB +: 2] = perr_way_i;
            flt_d[19:0]              = perr_index_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flt_q <= CPDR_FLT_RESET;
        end else begin
            flt_q <= flt_d;
        end
    end

    // tag and data transfer registers
    always_comb begin
        tag_d = tag_q;
        dat_d = dat_q;
        if (cop_wr_i && cop_sel_i == CPDR_SEL_TAG) begin
            tag_d = cop_wdata_i & tag_mask;
            if (!cop_wdata_i[CPDR_TAG_VALID]) begin
                tag_d[CPDR_TAG_DIRTY] = 1'b0;
            end
        end
        if (cop_wr_i && cop_sel_i == CPDR_SEL_DATA) begin
            dat_d = cop_wdata_i;
        end
        if (arr_ld_valid_i) begin
            if (way_select_test) begin
                // way-select view of the transfer register
                tag_d = 32'h0000_0000;
                tag_d[CPDR_TAG_DIRTY_PARITY_BITS_LSB +: 4] = arr_ld_ws_dpar_i;
                tag_d[CPDR_TAG_WSD_LSB +: 4]  = arr_ld_ws_dirty_i;
                tag_d[CPDR_TAG_LRU_LSB +: 6]  = arr_ld_ws_lru_i;
            end else begin
                // line address, state bits, tag parity
                tag_d = arr_ld_tag_i & CPDR_TAG_MASK_NORM;
                // parity bit taken from the tag array
                tag_d[CPDR_TAG_PAR] = par_on & arr_ld_tag_par_i;
            end
            // tag load also returns the data word
            dat_d = arr_ld_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tag_q <= 32'h0000_0000;
            dat_q <= 32'h0000_0000;
        end else begin
            tag_q <= tag_d;
            dat_q <= dat_d;
        end
    end

    // array steering for indexed cache operations
    always_comb begin
        tag_wr_d  = 1'b0;
        tag_rd_d  = 1'b0;
        ws_wr_d   = 1'b0;
        ws_rd_d   = 1'b0;
        data_wr_d = 1'b0;
        spad_wr_d = 1'b0;
        spad_rd_d = 1'b0;
        wdata_d   = wdata_q;
        wpar_d    = wpar_q;
        if (cop_op_i) begin
            case (cpdr_op_e'(cop_op_code_i))
                CPDR_OP_LOAD_TAG: begin
                    // scratchpad takes the op when routed
                    if (scratchpad_route) begin
                        spad_rd_d = 1'b1;
                    // test mode reads the way-select array
                    end else if (way_select_test) begin
                        ws_rd_d = 1'b1;
                    end else begin
                        tag_rd_d = 1'b1;
                    end
                end
                CPDR_OP_STORE_TAG: begin
                    wdata_d = tag_q;
                    // scratchpad takes the op when routed
                    if (scratchpad_route) begin
                        spad_wr_d = 1'b1;
                    // test mode writes the way-select array
                    end else if (way_select_test) begin
                        ws_wr_d = 1'b1;
                    end else begin
                        tag_wr_d = 1'b1;
                    end
                end
                CPDR_OP_STORE_DATA: begin
                    wdata_d = dat_q;
                    if (scratchpad_route) begin
                        spad_wr_d = 1'b1;
                    // data store allowed only in test mode
                    end else if (way_select_test) begin
                        data_wr_d = 1'b1;
                    end
                end
                default: begin
                    wdata_d = wdata_q;
                end
            endcase
        end
        // zero with parity off, stored parity under override, generated otherwise
        if (cop_op_i) begin
            if (!par_on) begin
                wpar_d = 4'h0;
            end else if (!override) begin
                wpar_d = (cop_op_code_i == 2'(CPDR_OP_STORE_DATA)) ? gen_bpar : {3'h0, gen_wpar};
            end else if (cop_op_code_i == 2'(CPDR_OP_STORE_DATA)) begin
                wpar_d = cop_op_icache_i ? ctl_q[CPDR_CTL_IPAR_LSB +: 4]
                                         : ctl_q[CPDR_CTL_DPAR_LSB +: 4];
            end else if (way_select_test) begin
                // dirty parity stored only under override
                wpar_d = tag_q[CPDR_TAG_DIRTY_PARITY_BITS_LSB +: 4];
            end else begin
                // tag parity written from transfer register
                wpar_d = {3'h0, tag_q[CPDR_TAG_PAR]};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tag_wr_q  <= 1'b0;
            tag_rd_q  <= 1'b0;
            ws_wr_q   <= 1'b0;
            ws_rd_q   <= 1'b0;
            data_wr_q <= 1'b0;
            spad_wr_q <= 1'b0;
            spad_rd_q <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wpar_q    <= 4'h0;
        end else begin
            tag_wr_q  <= tag_wr_d;
            tag_rd_q  <= tag_rd_d;
            ws_wr_q   <= ws_wr_d;
            ws_rd_q   <= ws_rd_d;
            data_wr_q <= data_wr_d;
            spad_wr_q <= spad_wr_d;
            spad_rd_q <= spad_rd_d;
            wdata_q   <= wdata_d;
            wpar_q    <= wpar_d;
        end
    end

    // return pc and instruction set select; exception capture beats a write
    always_comb begin
        pc_d  = pc_q;
        isa_d = isa_q;
        if (cop_wr_i && cop_sel_i == CPDR_SEL_RETPC) begin
            // pc bit 0 cleared, select taken from bit 0
            pc_d  = {cop_wdata_i[31:1], 1'b0};
            isa_d = {1'b0, cop_wdata_i[0]};
        end
        if (err_exc_i) begin
            // restart address supplied by the pipeline
            pc_d  = err_restart_pc_i;
            isa_d = {1'b0, err_isa_i};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pc_q  <= 32'h0000_0000;
            isa_q <= 2'h0;
        end else begin
            pc_q  <= pc_d;
            isa_q <= isa_d;
        end
    end

    // read mux, registered so the data shows one cycle after the read
    always_comb begin
        rdata_d = rdata_q;
        if (cop_rd_i) begin
            case (cop_sel_i)
                CPDR_SEL_CTRL:  rdata_d = ctl_q;
                CPDR_SEL_FAULT: rdata_d = flt_q;
                CPDR_SEL_TAG:   rdata_d = tag_q;
                CPDR_SEL_DATA:  rdata_d = dat_q;
                // upper 31 bits with low select bit
                CPDR_SEL_RETPC: rdata_d = {pc_q[31:1], isa_q[0]};
                default:        rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign cop_rdata_o        = rdata_q;
    assign tag_wr_o           = tag_wr_q;
    assign tag_rd_o           = tag_rd_q;
    assign ws_wr_o            = ws_wr_q;
    assign ws_rd_o            = ws_rd_q;
    assign data_wr_o          = data_wr_q;
    assign spad_wr_o          = spad_wr_q;
    assign spad_rd_o          = spad_rd_q;
    assign arr_wdata_o        = wdata_q;
    assign arr_wpar_o         = wpar_q;
    assign parity_on_o        = ctl_q[CPDR_CTL_PARITY_ON];
    assign instr_set_select_o = isa_q;
    assign fault_return_pc_o  = pc_q;
endmodule // cpdr_regs

// ### shared/cpdr_pkg.sv
// constants for the cache parity diagnostic register bank
package cpdr_pkg;
    // register selects on the coprocessor move port
    localparam logic [2:0] CPDR_SEL_CTRL    = 3'h0;
    localparam logic [2:0] CPDR_SEL_FAULT   = 3'h1;
    localparam logic [2:0] CPDR_SEL_TAG     = 3'h2;
    localparam logic [2:0] CPDR_SEL_DATA    = 3'h3;
    localparam logic [2:0] CPDR_SEL_RETPC   = 3'h4;
    // parity control fields
    localparam int CPDR_CTL_PARITY_ON  = 31;
    localparam int CPDR_CTL_OVERRIDE   = 30;
    localparam int CPDR_CTL_WST        = 29;
    localparam int CPDR_CTL_SPR        = 28;
    localparam int CPDR_CTL_IPAR_LSB   = 4;
    localparam int CPDR_CTL_DPAR_LSB   = 0;
    // fault capture fields
    localparam int CPDR_FLT_REF        = 31;
    localparam int CPDR_FLT_LEVEL      = 30;
    localparam int CPDR_FLT_DATA       = 29;
    localparam int CPDR_FLT_TAG        = 28;
    localparam int CPDR_FLT_SNOOP      = 27;
    localparam int CPDR_FLT_EXTERN     = 26;
    localparam int CPDR_FLT_BOTH       = 25;
    localparam int CPDR_FLT_FATAL      = 24;
    localparam int CPDR_FLT_SPAD       = 23;
    localparam int CPDR_FLT_WAYDIRTY   = 22;
    localparam int CPDR_FLT_WAY_LSB    = 20;
    // tag transfer fields
    localparam int CPDR_TAG_PA_LSB     = 10;
    localparam int CPDR_TAG_DIRTY_PARITY_BITS_LSB   = 20;
    localparam int CPDR_TAG_WSD_LSB    = 16;
    localparam int CPDR_TAG_LRU_LSB    = 10;
    localparam int CPDR_TAG_VALID      = 7;
    localparam int CPDR_TAG_DIRTY      = 6;
    localparam int CPDR_TAG_LOCK       = 5;
    localparam int CPDR_TAG_PAR        = 0;
    // writable masks and reset values
    localparam logic [31:0] CPDR_TAG_MASK_NORM = 32'hFFFF_FCE1;
    localparam logic [31:0] CPDR_TAG_MASK_WST  = 32'h00FF_FCE0;
    localparam logic [31:0] CPDR_CTL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CPDR_FLT_RESET     = 32'h0000_0000;
    // cache operation codes on the maintenance port
    typedef enum logic [1:0] {
        CPDR_OP_LOAD_TAG,
        CPDR_OP_STORE_TAG,
        CPDR_OP_STORE_DATA,
        CPDR_OP_NONE
    } cpdr_op_e;
endpackage

// ### hw/cpdr_parity.sv
// parity generator for tag and data words sent to the arrays
`timescale 1ns/1ps
module cpdr_parity
    import cpdr_pkg::*;
#(
    parameter int BYTES = 4
) (
    input  wire logic [8*BYTES-1:0] word_i,
    output logic      [BYTES-1:0]   byte_par_o,
    output logic                    word_par_o
);
    // one even-parity bit per byte lane
    genvar g;
    generate
        for (g = 0; g < BYTES; g++) begin : g_lane
            assign byte_par_o[g] = ^word_i[8*g +: 8];
        end
    endgenerate

    assign word_par_o = ^word_i;
endmodule // cpdr_parity

// ### sim/cpdr_regs_properties.sv
// assertion checker for the cache parity diagnostic register bank
`timescale 1ns/1ps
module cpdr_regs_properties
    import cpdr_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        cop_rd_i,
    input wire logic        cop_wr_i,
    input wire logic [2:0]  cop_sel_i,
    input wire logic [31:0] cop_wdata_i,
    input wire logic [31:0] cop_rdata_o,
    input wire logic        cop_op_i,
    input wire logic [1:0]  cop_op_code_i,
    input wire logic        tag_wr_o,
    input wire logic        tag_rd_o,
    input wire logic        ws_wr_o,
    input wire logic        ws_rd_o,
    input wire logic        data_wr_o,
    input wire logic        spad_wr_o,
    input wire logic        spad_rd_o,
    input wire logic        err_exc_i,
    input wire logic [31:0] err_restart_pc_i,
    input wire logic [1:0]  instr_set_select_o,
    input wire logic [31:0] fault_return_pc_o
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    AST_CTRL_ZERO: assert property (cop_rd_i && cop_sel_i == CPDR_SEL_CTRL
        |=> cop_rdata_o[27:8] == 20'h00000) else $error("control reserved bits not zero");
    AST_LEVEL_ZERO: assert property (cop_rd_i && cop_sel_i == CPDR_SEL_FAULT
        |=> !cop_rdata_o[30]) else $error("fault level bit not zero");
    AST_EXT_ZERO: assert property (cop_rd_i && cop_sel_i == CPDR_SEL_FAULT
        |=> !cop_rdata_o[26]) else $error("external fault bit not zero");
    AST_WS_NOT_TAG: assert property ((ws_wr_o || ws_rd_o) |-> !(tag_wr_o || tag_rd_o))
        else $error("way array and tag array both strobed");
    AST_SPAD_ALONE: assert property ((spad_wr_o || spad_rd_o)
        |-> !(tag_wr_o || tag_rd_o || ws_wr_o || ws_rd_o || data_wr_o))
        else $error("scratchpad strobe with cache strobe");
    AST_DATA_CAUSE: assert property (data_wr_o
        |-> $past(cop_op_i) && $past(cop_op_code_i) == CPDR_OP_STORE_DATA)
        else $error("data write without store data op");
    AST_TAG_CAUSE: assert property (tag_wr_o
        |-> $past(cop_op_i) && $past(cop_op_code_i) == CPDR_OP_STORE_TAG)
        else $error("tag write without store tag op");
    AST_PC_WRITE: assert property (cop_wr_i && cop_sel_i == CPDR_SEL_RETPC && !err_exc_i
        |=> fault_return_pc_o == ($past(cop_wdata_i) & 32'hFFFF_FFFE)
        && instr_set_select_o == 2'($past(cop_wdata_i) & 32'h1))
        else $error("return pc write split wrong");
    AST_PC_CAPTURE: assert property (err_exc_i
        |=> fault_return_pc_o == $past(err_restart_pc_i) && !instr_set_select_o[1])
        else $error("restart pc not captured");
endmodule // cpdr_regs_properties

// ### sim/tb_cpdr_regs.sv
// self-checking bench for the cache parity diagnostic register bank
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", what, (exp), (got)); end end
module tb_cpdr_regs
    import cpdr_pkg::*;
;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, cop_rd_i = 1'b0, cop_wr_i = 1'b0;
    logic        cop_op_i = 1'b0, cop_op_icache_i = 1'b0, arr_ld_valid_i = 1'b0;
    logic        arr_ld_tag_par_i = 1'b1, perr_i = 1'b0, err_exc_i = 1'b0, err_isa_i = 1'b0;
    logic        perr_data_ref_i = 1'b0, perr_data_ram_i = 1'b0, perr_tag_ram_i = 1'b0;
    logic        perr_snoop_i = 1'b0, perr_both_i = 1'b0, perr_dirty_victim_i = 1'b0;
    logic        perr_wb_miss_way_i = 1'b0, perr_spad_i = 1'b0, perr_way_dirty_i = 1'b0;
    logic [2:0]  cop_sel_i = 3'h0;
    logic [1:0]  cop_op_code_i = 2'h3, perr_way_i = 2'h0, instr_set_select_o;
    logic [31:0] cop_wdata_i = 32'h0, arr_ld_tag_i = 32'h0, arr_ld_data_i = 32'h0;
    logic [31:0] err_restart_pc_i = 32'h0, cop_rdata_o, arr_wdata_o, fault_return_pc_o;
    logic [3:0]  arr_ld_data_par_i = 4'h5, arr_ld_ws_dpar_i = 4'h3, arr_ld_ws_dirty_i = 4'h9;
    logic [3:0]  arr_wpar_o;
    logic [5:0]  arr_ld_ws_lru_i = 6'h2A;
    logic [19:0] perr_index_i = 20'h0;
    logic        tag_wr_o, tag_rd_o, ws_wr_o, ws_rd_o, data_wr_o, spad_wr_o, spad_rd_o;
    logic        parity_on_o;
    wire [6:0]   strb = {tag_wr_o, tag_rd_o, ws_wr_o, ws_rd_o, data_wr_o, spad_wr_o, spad_rd_o};
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    cpdr_regs dut (.clk_sys_i, .rst_i, .cop_rd_i, .cop_wr_i, .cop_sel_i, .cop_wdata_i,
        .cop_rdata_o, .cop_op_i, .cop_op_code_i, .cop_op_icache_i, .arr_ld_valid_i,
        .arr_ld_tag_i, .arr_ld_tag_par_i, .arr_ld_data_i, .arr_ld_data_par_i, .arr_ld_ws_dpar_i,
        .arr_ld_ws_dirty_i, .arr_ld_ws_lru_i, .tag_wr_o, .tag_rd_o, .ws_wr_o, .ws_rd_o,
        .data_wr_o, .spad_wr_o, .spad_rd_o, .arr_wdata_o, .arr_wpar_o, .parity_on_o, .perr_i,
        .perr_data_ref_i, .perr_data_ram_i, .perr_tag_ram_i, .perr_snoop_i, .perr_both_i,
        .perr_dirty_victim_i, .perr_wb_miss_way_i, .perr_spad_i, .perr_way_dirty_i,
        .perr_way_i, .perr_index_i, .err_exc_i, .err_restart_pc_i, .err_isa_i,
        .instr_set_select_o, .fault_return_pc_o);

    // 25 MHz core clock
    always #20 clk_sys_i = ~clk_sys_i;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(posedge clk_sys_i);
        cop_wr_i <= 1'b1;
        cop_sel_i <= s;
        cop_wdata_i <= d;
        @(posedge clk_sys_i);
        cop_wr_i <= 1'b0;
    endtask

    // read data lands one cycle after the read edge
    task automatic rd(input logic [2:0] s, input logic [31:0] exp);
        @(posedge clk_sys_i);
        cop_rd_i <= 1'b1;
        cop_sel_i <= s;
        @(posedge clk_sys_i);
        cop_rd_i <= 1'b0;
        #1;
        `CHK("register read", exp, cop_rdata_o);
    endtask

    task automatic op(input logic [1:0] c, input logic ic, input logic [6:0] st);
        @(posedge clk_sys_i);
        cop_op_i <= 1'b1;
        cop_op_code_i <= c;
        cop_op_icache_i <= ic;
        @(posedge clk_sys_i);
        cop_op_i <= 1'b0;
        #1;
        `CHK("strobes", st, strb);
    endtask

    task automatic ld(input logic [31:0] t, input logic [31:0] d);
        @(posedge clk_sys_i);
        arr_ld_valid_i <= 1'b1;
        arr_ld_tag_i <= t;
        arr_ld_data_i <= d;
        @(posedge clk_sys_i);
        arr_ld_valid_i <= 1'b0;
    endtask

    task automatic flt(input logic [8:0] f, input logic [1:0] w, input logic [19:0] ix,
                       input logic [31:0] exp);
        @(posedge clk_sys_i);
        perr_i <= 1'b1;
        {perr_data_ref_i, perr_data_ram_i, perr_tag_ram_i, perr_snoop_i, perr_both_i,
         perr_dirty_victim_i, perr_wb_miss_way_i, perr_spad_i, perr_way_dirty_i} <= f;
        perr_way_i <= w;
        perr_index_i <= ix;
        @(posedge clk_sys_i);
        perr_i <= 1'b0;
        rd(CPDR_SEL_FAULT, exp);
    endtask

    task automatic t_reset();
        for (int s = 0; s < 5; s++) begin
            rd(3'(s), 32'h0);
        end
        wr(3'h5, 32'hFFFF_FFFF);
        rd(3'h5, 32'h0);
        rd(3'h7, 32'h0);
    endtask

    // masks on control and tag transfer
    task automatic t_masks();
        wr(CPDR_SEL_CTRL, 32'hF000_00FF);
        rd(CPDR_SEL_CTRL, 32'hF000_00FF);
        `CHK("parity on", 1'b1, parity_on_o);
        wr(CPDR_SEL_TAG, 32'h0000_0040);
        rd(CPDR_SEL_TAG, 32'h0);
        wr(CPDR_SEL_CTRL, 32'h2000_0000);
        wr(CPDR_SEL_TAG, 32'hFFFF_FFFF);
        rd(CPDR_SEL_TAG, 32'h00FF_FCE0);
        wr(CPDR_SEL_CTRL, 32'h0);
        wr(CPDR_SEL_TAG, 32'hFFFF_FFFF);
        rd(CPDR_SEL_TAG, 32'hFFFF_FCE1);
        wr(CPDR_SEL_DATA, 32'h1234_5678);
        rd(CPDR_SEL_DATA, 32'h1234_5678);
    endtask

    // every op in every routing mode; scratchpad mode has parity on
    task automatic t_routing();
        logic [31:0] md [3] = '{32'h0, 32'h2000_0000, 32'h9000_0000};
        logic [6:0]  st [3][3] = '{'{7'h20, 7'h40, 7'h00}, '{7'h08, 7'h10, 7'h04},
                                   '{7'h01, 7'h02, 7'h02}};
        for (int m = 0; m < 3; m++) begin
            wr(CPDR_SEL_CTRL, md[m]);
            for (int c = 0; c < 3; c++) begin
                op(2'(c), 1'b0, st[m][c]);
                if (c > 0 && st[m][c] != 7'h00) begin
                    `CHK("write data", c == 1 ? 32'hFFFF_FCE1 : 32'h1234_5678, arr_wdata_o);
                    `CHK("write parity", m == 2 && c == 2 ? 4'h4 : 4'h0, arr_wpar_o);
                end
            end
        end
    endtask

    task automatic t_override();
        wr(CPDR_SEL_CTRL, 32'hC000_0000);
        op(CPDR_OP_STORE_TAG, 1'b0, 7'h40);
        `CHK("tag parity", 4'h1, arr_wpar_o);
        wr(CPDR_SEL_CTRL, 32'hE000_00A5);
        op(CPDR_OP_STORE_DATA, 1'b0, 7'h04);
        `CHK("dcache parity", 4'h5, arr_wpar_o);
        op(CPDR_OP_STORE_DATA, 1'b1, 7'h04);
        `CHK("icache parity", 4'hA, arr_wpar_o);
    endtask

    task automatic t_load();
        wr(CPDR_SEL_CTRL, 32'h8000_0000);
        op(CPDR_OP_LOAD_TAG, 1'b0, 7'h20);
        ld(32'hFFFF_FFFF, 32'hCAFE_F00D);
        rd(CPDR_SEL_TAG, 32'hFFFF_FCE1);
        rd(CPDR_SEL_DATA, 32'hCAFE_F00D);
        rd(CPDR_SEL_CTRL, 32'h8000_0005);
        op(CPDR_OP_LOAD_TAG, 1'b1, 7'h20);
        ld(32'h8000_0400, 32'h0BAD_BEEF);
        rd(CPDR_SEL_CTRL, 32'h8000_0055);
        rd(CPDR_SEL_TAG, 32'h8000_0401);
        wr(CPDR_SEL_CTRL, 32'hA000_0000);
        op(CPDR_OP_LOAD_TAG, 1'b0, 7'h08);
        ld(32'h0, 32'h0);
        rd(CPDR_SEL_TAG, 32'h0039_A800);
        wr(CPDR_SEL_CTRL, 32'h0);
        op(CPDR_OP_LOAD_TAG, 1'b0, 7'h20);
        ld(32'hFFFF_FFFF, 32'h1);
        rd(CPDR_SEL_CTRL, 32'h0);
        rd(CPDR_SEL_TAG, 32'hFFFF_FCE0);
    endtask

    task automatic t_fault();
        flt(9'b110100001, 2'h2, 20'hABCDE, 32'hA86A_BCDE);
        flt(9'b101010010, 2'h0, 20'h0, 32'h1380_0000);
        flt(9'b000001000, 2'h1, 20'h00018, 32'h0110_0018);
        flt(9'b000000100, 2'h3, 20'hF0000, 32'h013F_0000);
    endtask

    // return pc write, capture and read
    task automatic t_retpc();
        wr(CPDR_SEL_RETPC, 32'h8000_1235);
        #1;
        `CHK("return pc", 32'h8000_1234, fault_return_pc_o);
        `CHK("isa select", 2'h1, instr_set_select_o);
        rd(CPDR_SEL_RETPC, 32'h8000_1235);
        // capture must win over a software write in the same cycle
        @(posedge clk_sys_i);
        cop_wr_i <= 1'b1;
        cop_sel_i <= CPDR_SEL_RETPC;
        cop_wdata_i <= 32'h0;
        err_exc_i <= 1'b1;
        err_restart_pc_i <= 32'h0000_4002;
        err_isa_i <= 1'b1;
        @(posedge clk_sys_i);
        cop_wr_i <= 1'b0;
        err_exc_i <= 1'b0;
        #1;
        `CHK("restart pc", 32'h0000_4002, fault_return_pc_o);
        rd(CPDR_SEL_RETPC, 32'h0000_4003);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_masks();
        t_routing();
        t_override();
        t_load();
        t_fault();
        t_retpc();
        end_of_test();
    end
endmodule // tb_cpdr_regs

bind cpdr_regs cpdr_regs_properties u_props (.clk_sys_i, .rst_i, .cop_rd_i, .cop_wr_i,
    .cop_sel_i, .cop_wdata_i, .cop_rdata_o, .cop_op_i, .cop_op_code_i, .tag_wr_o, .tag_rd_o,
    .ws_wr_o, .ws_rd_o, .data_wr_o, .spad_wr_o, .spad_rd_o, .err_exc_i, .err_restart_pc_i,
    .instr_set_select_o, .fault_return_pc_o);
